// ===== hdl/aifc_pkg.sv
// Constants, register map and coefficient tables for the input filter control block.
package aifc_pkg;

  // Sample and coefficient widths.
  localparam int SMP_W = 24;
  localparam int COEF_W = 16;
  localparam int COEF_FRAC = 16;
  localparam int GAIN_W = 8;
  localparam int GAIN_FRAC = 7;

  // Bus geometry: each register index occupies one 32-bit word.
  localparam int ADR_W = 10;
  localparam int DAT_W = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_IN2L_PATH = 8'h1a;
  localparam logic [7:0] IDX_IN2R_PATH = 8'h1b;
  localparam logic [7:0] IDX_IN1_HPF = 8'hbc;
  localparam logic [7:0] IDX_IN2_HPF = 8'hbd;
  localparam logic [7:0] IDX_GAIN2L = 8'h40;
  localparam logic [7:0] IDX_GAIN2R = 8'h41;
  localparam logic [7:0] IDX_STATUS = 8'h42;
  localparam logic [7:0] IDX_CUR2L = 8'h43;
  localparam logic [7:0] IDX_CUR2R = 8'h44;

  // Path control fields.
  localparam int BIT_PATH_ON = 7;
  localparam int BIT_SILENCE = 6;
  localparam int BIT_GLIDE = 5;
  localparam logic [7:0] PATH_MASK = 8'he0;
  localparam logic [7:0] PATH_RST = 8'h00;

  // High-pass control fields.
  localparam int BIT_HPF_EN = 7;
  localparam int AUD_CORNER_LSB = 4;
  localparam int AUD_CORNER_W = 2;
  localparam int BIT_VOICE_EN = 3;
  localparam int VOI_CORNER_LSB = 0;
  localparam int VOI_CORNER_W = 3;
  localparam logic [7:0] HPF_MASK = 8'hbf;
  localparam logic [7:0] HPF_RST = 8'h80;

  // Gain: code 0x80 is unity.
  localparam logic [7:0] GAIN_RST = 8'h80;

  // Pole coefficients in Q0.16, fixed per code so corners follow the sample rate.
  function automatic logic [COEF_W-1:0] audio_coef(input logic [AUD_CORNER_W-1:0] code);
    case (code)
      2'h0: audio_coef = 16'hffef;
      2'h1: audio_coef = 16'hffde;
      2'h2: audio_coef = 16'hffbb;
      default: audio_coef = 16'hff77;
    endcase
  endfunction

  function automatic logic [COEF_W-1:0] voice_coef(input logic [VOI_CORNER_W-1:0] code);
    case (code)
      3'h0: voice_coef = 16'hff7f;
      3'h1: voice_coef = 16'hfaf9;
      3'h2: voice_coef = 16'hf5f2;
      3'h3: voice_coef = 16'hebe5;
      3'h4: voice_coef = 16'he1d7;
      3'h5: voice_coef = 16'hd7ca;
      3'h6: voice_coef = 16'hc3af;
      default: voice_coef = 16'haf94;
    endcase
  endfunction

endpackage

// ===== hdl/aifc_hpf.sv
// One-pole high-pass section with bypass, one sample per strobe.
`timescale 1ns/1ps
module aifc_hpf
  import aifc_pkg::*;
#(
  parameter int W = SMP_W
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic en,
  input wire logic [COEF_W-1:0] coef,
  // Sample in
  input wire logic in_stb,
  input wire logic signed [W-1:0] in_smp,
  // Sample out
  output logic out_stb,
  output logic signed [W-1:0] out_smp
);

  if (W < 8 || W > 32)
  begin : g_bad_width
    $error("aifc_hpf: sample width out of range");
  end

  typedef struct packed {
    logic signed [W-1:0] x1;
    logic signed [W+1:0] y1;
    logic stb;
    logic signed [W-1:0] y;
  } aifc_hpf_state_t;

  aifc_hpf_state_t s_reg;
  aifc_hpf_state_t s_next;

  function automatic logic signed [W-1:0] sat(input logic signed [W+1:0] v);
    if (v > $signed({3'b000, {(W-1){1'b1}}}))
      sat = {1'b0, {(W-1){1'b1}}};
    else if (v < $signed({3'b111, {(W-1){1'b0}}}))
      sat = {1'b1, {(W-1){1'b0}}};
    else
      sat = v[W-1:0];
  endfunction

  always_comb
  begin
    logic signed [W+1:0] acc;
    logic signed [W+COEF_W+2:0] prod;
    acc = '0;
    prod = '0;
    s_next = s_reg;
    s_next.stb = in_stb;
    if (in_stb)
    begin
      // y[n] = a * (y[n-1] + x[n] - x[n-1]).
      acc = s_reg.y1 + (W+2)'(in_smp) - (W+2)'(s_reg.x1);
      prod = (W+COEF_W+3)'(acc) * $signed({1'b0, coef});
      s_next.x1 = in_smp;
      if (en)
      begin
        s_next.y1 = prod[COEF_FRAC+W+1:COEF_FRAC];
        s_next.y = sat(prod[COEF_FRAC+W+1:COEF_FRAC]);
      end
      else
      begin
        // Input history keeps tracking while bypassed, so enabling starts with DC cancelled.
        s_next.y1 = '0;
        s_next.y = in_smp;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign out_stb = s_reg.stb;
  assign out_smp = s_reg.y;

endmodule // aifc_hpf

// ===== hdl/aifc_top.sv
// Record-path input filter control: registers, high-pass chains, mute and gain ramp.
`timescale 1ns/1ps
// Behaviour
// - Channel 2 left and right pass samples through their filter only while path-on bit 7 is set.
// - Channel 2 left and right gain goes to zero while silence bit 6 is set, ramping down if glide bit 5 is set.
// - With glide bit 5 clear a gain change applies at once, with it set the gain ramps.
// - Channels 1 and 2 apply the audio high-pass filter when enable bit 7 is set, else bypass.
// - Audio high-pass enables reset to 1; path-on, silence and glide bits reset to 0.
// - Audio corner field bits 5:4 selects 2, 4, 8 or 16 Hz at 48 kHz.
// - Coefficients are fixed per code so the corners scale with the sample rate.
// - The voice high-pass filter is applied only while voice bit 3 is set; it resets to 0.
// - Voice corner field bits 2:0 selects 2.5 to 400 Hz at 8 kHz.
module aifc_top
  import aifc_pkg::*;
#(
  parameter int W = SMP_W
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Samples from the decimation path
  input wire logic smp_in_stb,
  input wire logic signed [W-1:0] smp_in_1l,
  input wire logic signed [W-1:0] smp_in_1r,
  input wire logic signed [W-1:0] smp_in_2l,
  input wire logic signed [W-1:0] smp_in_2r,
  // Samples toward the mixer
  output logic smp_out_stb,
  output logic signed [W-1:0] smp_out_1l,
  output logic signed [W-1:0] smp_out_1r,
  output logic signed [W-1:0] smp_out_2l,
  output logic signed [W-1:0] smp_out_2r
);

  if (W < 8 || W > 32)
  begin : g_bad_width
    $error("aifc_top: sample width out of range");
  end

  localparam int NCH = 4;

  typedef struct packed {
    logic [7:0] path_l;
    logic [7:0] path_r;
    logic [7:0] hpf1;
    logic [7:0] hpf2;
    logic [GAIN_W-1:0] gain_l;
    logic [GAIN_W-1:0] gain_r;
    logic [GAIN_W-1:0] cur_l;
    logic [GAIN_W-1:0] cur_r;
    logic ack;
    logic [7:0] rdat;
    logic stb;
    logic signed [W-1:0] o1l;
    logic signed [W-1:0] o1r;
    logic signed [W-1:0] o2l;
    logic signed [W-1:0] o2r;
  } aifc_state_t;

  aifc_state_t s_reg;
  aifc_state_t s_next;

  // Filter chain wiring, channel order 1L, 1R, 2L, 2R.
  logic signed [W-1:0] ch_in [NCH];
  logic signed [W-1:0] hp_out [NCH];
  logic signed [W-1:0] vo_out [NCH];
  logic hp_stb [NCH];
  logic vo_stb [NCH];
  logic aud_en [NCH];
  logic voi_en [NCH];
  logic [COEF_W-1:0] aud_cf [NCH];
  logic [COEF_W-1:0] voi_cf [NCH];

  assign ch_in[0] = smp_in_1l;
  assign ch_in[1] = smp_in_1r;
  assign ch_in[2] = smp_in_2l;
  assign ch_in[3] = smp_in_2r;

  // Step the applied gain one code toward the target, or jump when not gliding.
  function automatic logic [GAIN_W-1:0] gain_step(
    input logic [GAIN_W-1:0] cur,
    input logic [GAIN_W-1:0] tgt,
    input logic glide
  );
    if (!glide)
      gain_step = tgt;
    else if (cur < tgt)
      gain_step = cur + 8'h01;
    else if (cur > tgt)
      gain_step = cur - 8'h01;
    else
      gain_step = cur;
  endfunction

  // Scale a sample by a gain code, saturating to the sample width.
  function automatic logic signed [W-1:0] apply_gain(
    input logic signed [W-1:0] x,
    input logic [GAIN_W-1:0] g
  );
    logic signed [W+GAIN_W:0] p;
    logic signed [W+GAIN_W:0] q;
    p = (W+GAIN_W+1)'(x) * $signed({1'b0, g});
    q = p >>> GAIN_FRAC;
    if (q > $signed((W+GAIN_W+1)'({1'b0, {(W-1){1'b1}}})))
      apply_gain = {1'b0, {(W-1){1'b1}}};
    else if (q < -$signed((W+GAIN_W+1)'({1'b0, {(W-1){1'b1}}})) - 1)
      apply_gain = {1'b1, {(W-1){1'b0}}};
    else
      apply_gain = q[W-1:0];
  endfunction

  // Gain target: zero while silenced, so mute follows the glide setting too.
  function automatic logic [GAIN_W-1:0] gain_target(
    input logic [7:0] path,
    input logic [GAIN_W-1:0] gain
  );
    gain_target = path[BIT_SILENCE] ? '0 : gain;
  endfunction

  // Register read decode; reserved bits and unmapped indices read as zero.
  function automatic logic [7:0] read_reg(input aifc_state_t s, input logic [7:0] idx);
    case (idx)
      IDX_IN2L_PATH: read_reg = s.path_l & PATH_MASK;
      IDX_IN2R_PATH: read_reg = s.path_r & PATH_MASK;
      IDX_IN1_HPF: read_reg = s.hpf1 & HPF_MASK;
      IDX_IN2_HPF: read_reg = s.hpf2 & HPF_MASK;
      IDX_GAIN2L: read_reg = s.gain_l;
      IDX_GAIN2R: read_reg = s.gain_r;
      IDX_STATUS: read_reg = {4'h0,
        (s.cur_r == '0), (s.cur_l == '0),
        (s.cur_r != gain_target(s.path_r, s.gain_r)),
        (s.cur_l != gain_target(s.path_l, s.gain_l))};
      IDX_CUR2L: read_reg = s.cur_l;
      IDX_CUR2R: read_reg = s.cur_r;
      default: read_reg = 8'h00;
    endcase
  endfunction

  // Per-channel filter controls; channels 1 and 2 share their pair's register.
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      logic [7:0] h;
      logic on;
      h = (c < 2) ? s_reg.hpf1 : s_reg.hpf2;
      on = 1'b1;
      if (c == 2)
        on = s_reg.path_l[BIT_PATH_ON];
      if (c == 3)
        on = s_reg.path_r[BIT_PATH_ON];
      aud_en[c] = h[BIT_HPF_EN] & on;
      voi_en[c] = h[BIT_VOICE_EN] & on;
      aud_cf[c] = audio_coef(h[AUD_CORNER_LSB +: AUD_CORNER_W]);
      voi_cf[c] = voice_coef(h[VOI_CORNER_LSB +: VOI_CORNER_W]);
    end
  end

  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    aifc_hpf #(
      .W(W)
    ) u_audio (
      .clk(clk),
      .nrst(nrst),
      .en(aud_en[c]),
      .coef(aud_cf[c]),
      .in_stb(smp_in_stb),
      .in_smp(ch_in[c]),
      .out_stb(hp_stb[c]),
      .out_smp(hp_out[c])
    );

    aifc_hpf #(
      .W(W)
    ) u_voice (
      .clk(clk),
      .nrst(nrst),
      .en(voi_en[c]),
      .coef(voi_cf[c]),
      .in_stb(hp_stb[c]),
      .in_smp(hp_out[c]),
      .out_stb(vo_stb[c]),
      .out_smp(vo_out[c])
    );
  end

  always_comb
  begin
    logic [7:0] idx;
    logic req;
    idx = wb_adr_i[ADR_W-1:2];
    req = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    s_next = s_reg;

    // Bus slave: answer every request one cycle later, unmapped ones included.
    s_next.ack = req;
    s_next.rdat = read_reg(s_reg, idx);
    if (req && wb_we_i && wb_sel_i[0])
    begin
      case (idx)
        IDX_IN2L_PATH: s_next.path_l = wb_dat_i[7:0] & PATH_MASK;
        IDX_IN2R_PATH: s_next.path_r = wb_dat_i[7:0] & PATH_MASK;
        IDX_IN1_HPF: s_next.hpf1 = wb_dat_i[7:0] & HPF_MASK;
        IDX_IN2_HPF: s_next.hpf2 = wb_dat_i[7:0] & HPF_MASK;
        IDX_GAIN2L: s_next.gain_l = wb_dat_i[7:0];
        IDX_GAIN2R: s_next.gain_r = wb_dat_i[7:0];
        default: ;
      endcase
    end

    // Output stage runs once per sample so muted channels keep their cadence.
    s_next.stb = vo_stb[0];
    if (vo_stb[0])
    begin
      s_next.cur_l = gain_step(s_reg.cur_l, gain_target(s_reg.path_l, s_reg.gain_l),
        s_reg.path_l[BIT_GLIDE]);
      s_next.cur_r = gain_step(s_reg.cur_r, gain_target(s_reg.path_r, s_reg.gain_r),
        s_reg.path_r[BIT_GLIDE]);
      s_next.o1l = vo_out[0];
      s_next.o1r = vo_out[1];
      // A disabled path emits zeros rather than stalling the mixer.
      s_next.o2l = s_reg.path_l[BIT_PATH_ON] ? apply_gain(vo_out[2], s_reg.cur_l) : '0;
      s_next.o2r = s_reg.path_r[BIT_PATH_ON] ? apply_gain(vo_out[3], s_reg.cur_r) : '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_reg <= '0;
      s_reg.path_l <= PATH_RST;
      s_reg.path_r <= PATH_RST;
      s_reg.hpf1 <= HPF_RST;
      s_reg.hpf2 <= HPF_RST;
      s_reg.gain_l <= GAIN_RST;
      s_reg.gain_r <= GAIN_RST;
    end
    else
      s_reg <= s_next;
  end

  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = {24'h000000, s_reg.rdat};
  assign smp_out_stb = s_reg.stb;
  assign smp_out_1l = s_reg.o1l;
  assign smp_out_1r = s_reg.o1r;
  assign smp_out_2l = s_reg.o2l;
  assign smp_out_2r = s_reg.o2r;

endmodule // aifc_top

// ===== test/aifc_props.sv
// Concurrent checks on the bus and sample stream of the input filter block.
`timescale 1ns/1ps
module aifc_props
  import aifc_pkg::*;
#(
  parameter int W = SMP_W
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Stream
  input wire logic smp_in_stb,
  input wire logic smp_out_stb,
  input wire logic signed [W-1:0] smp_out_2l,
  input wire logic signed [W-1:0] smp_out_2r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Shadows of the path-on bits; writes land at the edge that takes them.
  logic off_l_reg;
  logic off_r_reg;
  always_ff @(posedge clk)
  begin
    if (!nrst)
      off_r_reg <= 1'b1;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
             && wb_adr_i[9:2] == IDX_IN2R_PATH)
      off_r_reg <= !wb_dat_i[BIT_PATH_ON];
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      off_l_reg <= 1'b1;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
             && wb_adr_i[9:2] == IDX_IN2L_PATH)
      off_l_reg <= !wb_dat_i[BIT_PATH_ON];
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    ##1 wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_one_cycle: assert property (s_req |-> s_ack)
    else $error("ack not a single pulse one cycle after request");
  chk_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  chk_rdata_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_path_reserved: assert property (wb_ack_o && !$past(wb_we_i)
    && ($past(wb_adr_i) & 10'h3fc) == {IDX_IN2L_PATH, 2'b00} |-> wb_dat_o[4:0] == 5'h0)
    else $error("path register reserved bits set");
  chk_hpf_reserved: assert property (wb_ack_o && !$past(wb_we_i)
    && ($past(wb_adr_i) & 10'h3fc) == {IDX_IN1_HPF, 2'b00} |-> !wb_dat_o[6])
    else $error("high-pass register reserved bit set");
  chk_out_latency: assert property (smp_in_stb |-> ##3 smp_out_stb)
    else $error("output strobe not three cycles after input");
  chk_out_cause: assert property (smp_out_stb |-> $past(smp_in_stb, 3))
    else $error("output strobe without input");
  chk_data_hold: assert property (!smp_out_stb |-> $stable(smp_out_2l) && $stable(smp_out_2r))
    else $error("output samples changed between strobes");
  // The output register uses the path bit as it stood one edge before the strobe shows.
  chk_off_is_zero: assert property (smp_out_stb && $past(off_l_reg)
    |-> smp_out_2l == '0)
    else $error("disabled left channel gave nonzero sample");
  chk_off_right_zero: assert property (smp_out_stb && $past(off_r_reg)
    |-> smp_out_2r == '0)
    else $error("disabled right channel gave nonzero sample");
endmodule // aifc_props
bind aifc_top aifc_props #(.W(W)) u_aifc_props (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .smp_in_stb(smp_in_stb),
  .smp_out_stb(smp_out_stb), .smp_out_2l(smp_out_2l), .smp_out_2r(smp_out_2r));

// ===== test/aifc_src_model.sv
// Behavioural decimation path: one sample set every eight clocks while running.
`timescale 1ns/1ps
module aifc_src_model
  import aifc_pkg::*;
#(
  parameter int W = SMP_W
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic run,
  input wire logic signed [W-1:0] level,
  // Toward the design
  output logic stb,
  output logic signed [W-1:0] smp
);
  logic [2:0] cnt_reg;
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt_reg <= 3'h0;
      stb <= 1'b0;
      smp <= '0;
    end
    else
    begin
      cnt_reg <= cnt_reg + 3'h1;
      stb <= run && cnt_reg == 3'h0;
      // Data toggles between strobes so nothing may lean on a stale value.
      smp <= (run && cnt_reg == 3'h0) ? level : ~smp;
    end
  end
endmodule // aifc_src_model

// ===== test/test_aifc_top.sv
// Self-checking bench for the input filter control block.
`timescale 1ns/1ps
module test_aifc_top
  import aifc_pkg::*;
;
  logic clk, nrst, cyc, stb, we, run, ack, istb, ostb;
  logic [ADR_W-1:0] adr;
  logic [DAT_W-1:0] wdat, rdat, rd_o, g0;
  logic [3:0] sel;
  logic signed [SMP_W-1:0] ismp, lvl, o1l, o1r, o2l, o2r;
  int mismatches, n_tests;
  localparam logic [23:0] ROWS [5] = '{24'h1affe0, 24'h1bffe0, 24'hbcffbf, 24'hbd7f3f, 24'h55ff00};
  localparam logic [15:0] RSTV [4] = '{16'h1a00, 16'h1b00, 16'hbc80, 16'hbd80};
  aifc_top u_aifc_top (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rd_o), .wb_ack_o(ack),
    .smp_in_stb(istb), .smp_in_1l(ismp), .smp_in_1r(ismp), .smp_in_2l(ismp),
    .smp_in_2r(ismp), .smp_out_stb(ostb), .smp_out_1l(o1l), .smp_out_1r(o1r),
    .smp_out_2l(o2l), .smp_out_2r(o2r));
  aifc_src_model u_aifc_src_model (.clk(clk), .nrst(nrst), .run(run), .level(lvl),
    .stb(istb), .smp(ismp));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic summarize;
    $display("Counts: %0d checks, %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    sel <= 4'h1;
    @(posedge clk);
    while (ack !== 1'b1 && k < 50)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 50)
    begin
      mismatches++;
      $display("Error bus ack expected 1 seen 0");
    end
    rdat = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic outs(input int n);
    int k;
    repeat (n)
    begin
      k = 0;
      @(posedge clk);
      while (ostb !== 1'b1 && k < 100)
      begin
        @(posedge clk);
        k++;
      end
      if (k >= 100)
      begin
        mismatches++;
        $display("Error smp_out_stb expected 1 seen 0");
      end
    end
  endtask
  initial
  begin
    nrst = 1'b0;
    {cyc, stb, we, run, adr, wdat, sel} = '0;
    lvl = 24'h001234;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    foreach (ROWS[i])
    begin
      bus(1'b1, ROWS[i][23:16], ROWS[i][15:8]);
      bus(1'b0, ROWS[i][23:16], 8'h00);
      check("register", {24'h0, ROWS[i][7:0]}, rdat);
    end
    $display("test registers done");
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    foreach (RSTV[i])
    begin
      bus(1'b0, RSTV[i][15:8], 8'h00);
      check("reset value", {24'h0, RSTV[i][7:0]}, rdat);
    end
    $display("test reset done");
    bus(1'b1, IDX_IN1_HPF, 8'h00);
    bus(1'b1, IDX_IN2_HPF, 8'h00);
    bus(1'b1, IDX_IN2L_PATH, 8'h80);
    run <= 1'b1;
    outs(3);
    check("out_2l", lvl, o2l);
    check("out_2r", 32'h0, o2r);
    check("out_1l", lvl, o1l);
    bus(1'b1, IDX_IN2_HPF, 8'h80);
    outs(4);
    check("out_2l below input", 32'h1, o2l < lvl);
    check("out_1r", lvl, o1r);
    bus(1'b1, IDX_IN1_HPF, 8'h08);
    outs(3);
    check("out_1l voice", 32'h1, o1l < lvl);
    check("out_1r voice", 32'h1, o1r < lvl);
    $display("test path done");
    bus(1'b1, IDX_IN2_HPF, 8'h00);
    bus(1'b1, IDX_IN2L_PATH, 8'hc0);
    outs(2);
    check("muted", 32'h0, o2l);
    bus(1'b1, IDX_IN2L_PATH, 8'ha0);
    outs(2);
    bus(1'b0, IDX_CUR2L, 8'h00);
    g0 = rdat;
    outs(4);
    bus(1'b0, IDX_CUR2L, 8'h00);
    check("glide", g0 + 32'h4, rdat);
    bus(1'b1, IDX_IN2L_PATH, 8'h80);
    outs(2);
    bus(1'b0, IDX_CUR2L, 8'h00);
    check("step", {24'h0, GAIN_RST}, rdat);
    bus(1'b1, IDX_IN2L_PATH, 8'h00);
    outs(2);
    check("off_2l", 32'h0, o2l);
    $display("test gain done");
    summarize();
  end
  // The tests need a few hundred cycles; this leaves ample margin.
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule // test_aifc_top
